/* File: hdl/dctu_unit.sv */
`timescale 1ns/1ps
module dctu_unit #(
  parameter int N_WINDOWS = 8,
  parameter int CWP_W = 3,
  parameter int ST_W = 40,
  parameter int TL_DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic insn_valid,
  input dctu_pkg::dctu_kind_t insn_kind,
  input wire logic cond_true,
  input wire logic annul,
  input wire logic [dctu_pkg::DISP_W-1:0] disp_word,
  input dctu_pkg::dctu_form_t disp_form,
  input wire logic [dctu_pkg::ADDR_W-1:0] first_source_reg,
  input wire logic [dctu_pkg::ADDR_W-1:0] second_source_reg,
  input wire logic imm_sel,
  input wire logic [dctu_pkg::IMM_W-1:0] signed_imm_field,
  input wire logic [dctu_pkg::REG_IDX_W-1:0] dest_reg_idx,
  input wire logic addr_mask_32_flag,
  input wire logic privileged,
  input wire logic [dctu_pkg::TB_W-1:0] trap_base_reg,
  input wire logic [ST_W-1:0] machine_state,
  output logic insn_ready,
  output logic [dctu_pkg::ADDR_W-1:0] prog_counter,
  output logic [dctu_pkg::ADDR_W-1:0] next_prog_counter,
  output logic [dctu_pkg::TL_W-1:0] trap_level,
  output logic [dctu_pkg::TT_W-1:0] trap_type_reg,
  output logic [CWP_W-1:0] current_window_pointer,
  output logic link_wr_en,
  output logic [dctu_pkg::REG_IDX_W-1:0] link_wr_idx,
  output logic [dctu_pkg::ADDR_W-1:0] link_wr_data,
  output logic state_restore,
  output logic [ST_W-1:0] saved_trap_state,
  output logic trap_taken,
  output logic illegal_insn_exc,
  output logic priv_opcode_exc,
  output logic soft_reset_req
);
  import dctu_pkg::*;

  //////////////////////////////////////////////////////////////////////////////

  logic accept;
  logic [ADDR_W-1:0] pcrel_target;
  logic [ADDR_W-1:0] regind_target;
  logic [TT_W-1:0] sw_trap_type;
  logic [ADDR_W-1:0] trap_vector;
  logic [ADDR_W-1:0] stk_pc;
  logic [ADDR_W-1:0] stk_next_pc;
  logic [ST_W-1:0] stk_state;
  logic [ADDR_W-1:0] seq_npc;
  logic [ADDR_W-1:0] skip_pc;
  logic [ADDR_W-1:0] skip_npc;
  logic [ADDR_W-1:0] link_value;
  logic [TL_W-1:0] tl_up;
  logic [TL_W-1:0] tl_down;
  logic [CWP_W-1:0] cwp_down;

  logic [ADDR_W-1:0] next_pc;
  logic [ADDR_W-1:0] next_npc;
  logic [TL_W-1:0] next_tl;
  logic [TT_W-1:0] next_tt;
  logic [CWP_W-1:0] next_cwp;
  logic next_link_en;
  logic [REG_IDX_W-1:0] next_link_idx;
  logic next_restore;
  logic next_trap;
  logic next_illegal;
  logic next_priv;
  logic next_swreset;
  logic tl_moves;

  assign accept = insn_valid & insn_ready;

  assign seq_npc = next_prog_counter + PC_STEP;
  assign skip_pc = next_prog_counter + PC_STEP;
  assign skip_npc = next_prog_counter + PC_STEP2;

  assign link_value = addr_mask_32_flag ? {UPPER_ZERO, prog_counter[31:0]} : prog_counter;

  assign tl_up = (trap_level == TL_MAX) ? trap_level : trap_level + 3'h1;
  assign tl_down = (trap_level == TL_RESET) ? trap_level : trap_level - 3'h1;
  assign cwp_down = (current_window_pointer == '0) ?
      CWP_W'(N_WINDOWS - 1) : current_window_pointer - CWP_W'(1);

  //////////////////////////////////////////////////////////////////////////////

  dctu_target u_target (
    .pc(prog_counter),
    .disp_word(disp_word),
    .disp_form(disp_form),
    .first_source_reg(first_source_reg),
    .second_source_reg(second_source_reg),
    .imm_sel(imm_sel),
    .signed_imm_field(signed_imm_field),
    .trap_base_reg(trap_base_reg),
    .tl_nonzero(trap_level != TL_RESET),
    .pcrel_target(pcrel_target),
    .regind_target(regind_target),
    .sw_trap_type(sw_trap_type),
    .trap_vector(trap_vector)
  );

  // The trap stack holds saved PC, next-PC and state per trap level.
  dctu_trap_stack #(
    .DEPTH(TL_DEPTH),
    .AW(TL_W),
    .PC_W(ADDR_W),
    .ST_W(ST_W)
  ) u_stack (
    .clk(clk),
    .wr_en(next_trap),
    .wr_level(tl_up),
    .wr_pc(prog_counter),
    .wr_next_pc(next_prog_counter),
    .wr_state(machine_state),
    .rd_level(trap_level),
    .rd_pc(stk_pc),
    .rd_next_pc(stk_next_pc),
    .rd_state(stk_state)
  );

  //////////////////////////////////////////////////////////////////////////////

  always_comb begin
    next_pc = prog_counter;
    next_npc = next_prog_counter;
    next_tl = trap_level;
    next_tt = trap_type_reg;
    next_cwp = current_window_pointer;
    next_link_en = 1'b0;
    next_link_idx = dest_reg_idx;
    next_restore = 1'b0;
    next_trap = 1'b0;
    next_illegal = 1'b0;
    next_priv = 1'b0;
    next_swreset = 1'b0;
    if (accept) begin
      case (insn_kind)
        KIND_BCOND: begin
          if (cond_true) begin
            next_pc = next_prog_counter;
            next_npc = pcrel_target;
          end else if (annul) begin
            next_pc = skip_pc;
            next_npc = skip_npc;
          end else begin
            next_pc = next_prog_counter;
            next_npc = seq_npc;
          end
        end
        KIND_BUNCOND: begin
          if (cond_true && annul) begin
            next_pc = pcrel_target;
            next_npc = pcrel_target + PC_STEP;
          end else if (cond_true) begin
            next_pc = next_prog_counter;
            next_npc = pcrel_target;
          end else if (annul) begin
            next_pc = skip_pc;
            next_npc = skip_npc;
          end else begin
            next_pc = next_prog_counter;
            next_npc = seq_npc;
          end
        end
        KIND_CALL: begin
          next_pc = next_prog_counter;
          next_npc = pcrel_target;
          next_link_en = 1'b1;
          next_link_idx = LINK_REG;
        end
        KIND_JLINK: begin
          next_pc = next_prog_counter;
          next_npc = regind_target;
          next_link_en = 1'b1;
        end
        KIND_RETURN: begin
          next_pc = next_prog_counter;
          next_npc = regind_target;
          next_cwp = cwp_down;
        end
        KIND_DONE: begin
          if (privileged) begin
            next_pc = stk_next_pc;
            next_npc = stk_next_pc + PC_STEP;
            next_tl = tl_down;
            next_restore = 1'b1;
          end else begin
            next_priv = 1'b1;
          end
        end
        KIND_RETRY: begin
          if (privileged) begin
            next_pc = stk_pc;
            next_npc = stk_next_pc;
            next_tl = tl_down;
            next_restore = 1'b1;
          end else begin
            next_priv = 1'b1;
          end
        end
        KIND_TCOND: begin
          if (cond_true) begin
            next_tl = tl_up;
            next_tt = sw_trap_type;
            next_pc = trap_vector;
            next_npc = trap_vector + PC_STEP;
            next_trap = 1'b1;
          end else begin
            next_pc = next_prog_counter;
            next_npc = seq_npc;
          end
        end
        KIND_ILLEGAL_TRAP_INSN: begin
          next_illegal = 1'b1;
        end
        KIND_SWRESET: begin
          if (privileged) begin
            next_swreset = 1'b1;
          end else begin
            next_pc = next_prog_counter;
            next_npc = seq_npc;
          end
        end
        KIND_INSN_A: begin
          if (privileged) begin
            next_pc = next_prog_counter;
            next_npc = seq_npc;
          end else begin
            next_priv = 1'b1;
          end
        end
        KIND_NONCTI, KIND_NOP: begin
          next_pc = next_prog_counter;
          next_npc = seq_npc;
        end
        default: begin
          next_illegal = 1'b1;
        end
      endcase
    end
  end

  // A trap level change leaves the registered stack read stale for one cycle.
  assign tl_moves = (next_tl != trap_level);

  //////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk) begin
    if (reset) begin
      prog_counter <= RESET_PC_VAL;
      next_prog_counter <= RESET_PC_VAL + PC_STEP;
      trap_level <= TL_RESET;
      trap_type_reg <= TT_RESET;
      current_window_pointer <= '0;
    end else begin
      prog_counter <= next_pc;
      next_prog_counter <= next_npc;
      trap_level <= next_tl;
      trap_type_reg <= next_tt;
      current_window_pointer <= next_cwp;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      saved_trap_state <= '0;
      state_restore <= 1'b0;
    end else begin
      state_restore <= next_restore;
      if (next_restore) begin
        saved_trap_state <= stk_state;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      link_wr_en <= 1'b0;
      link_wr_idx <= '0;
      link_wr_data <= '0;
    end else begin
      link_wr_en <= next_link_en;
      link_wr_idx <= next_link_idx;
      link_wr_data <= link_value;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      insn_ready <= 1'b0;
      trap_taken <= 1'b0;
      illegal_insn_exc <= 1'b0;
      priv_opcode_exc <= 1'b0;
      soft_reset_req <= 1'b0;
    end else begin
      insn_ready <= ~tl_moves;
      trap_taken <= next_trap;
      illegal_insn_exc <= next_illegal;
      priv_opcode_exc <= next_priv;
      soft_reset_req <= next_swreset;
    end
  end

endmodule : dctu_unit

/* File: hdl/dctu_pkg.sv */
package dctu_pkg;

  localparam int ADDR_W = 64;
  localparam int TL_W = 3;
  localparam int REG_IDX_W = 5;
  localparam int DISP_W = 30;
  localparam int IMM_W = 13;
  localparam int TT_W = 9;
  localparam int SW_TRAP_BITS = 7;

  // Displacement field widths per branch form, in bits; the fields count words.
  localparam int DISP_CC_NOPRED_W = 22;
  localparam int DISP_CC_PRED_W = 19;
  localparam int DISP_REG_W = 16;
  localparam int DISP_CALL_W = 30;
  localparam int WORD_SHIFT = 2;

  // Trap vector layout: base above TB_LSB, level bit, type, then zeros.
  localparam int TB_LSB = 15;
  localparam int TB_W = ADDR_W - TB_LSB;
  localparam int TL_BIT_POS = 14;
  localparam int TT_LSB = 5;

  localparam logic [ADDR_W-1:0] PC_STEP = 64'h0000_0000_0000_0004;
  localparam logic [ADDR_W-1:0] PC_STEP2 = 64'h0000_0000_0000_0008;
  localparam logic [ADDR_W-1:0] RESET_PC_VAL = 64'h0000_0000_0000_0000;
  localparam logic [REG_IDX_W-1:0] LINK_REG = 5'h0f;
  localparam logic [TT_W-1:0] SW_TRAP_BASE = 9'h100;
  localparam logic [TL_W-1:0] TL_RESET = 3'h0;
  localparam logic [TL_W-1:0] TL_MAX = 3'h5;
  localparam logic [TT_W-1:0] TT_RESET = 9'h000;
  localparam logic [31:0] UPPER_ZERO = 32'h0000_0000;

  typedef enum logic [3:0] {
    KIND_NONCTI = 4'b0000,
    KIND_BCOND = 4'b0001,
    KIND_BUNCOND = 4'b0010,
    KIND_CALL = 4'b0011,
    KIND_JLINK = 4'b0100,
    KIND_RETURN = 4'b0101,
    KIND_DONE = 4'b0110,
    KIND_RETRY = 4'b0111,
    KIND_TCOND = 4'b1000,
    KIND_ILLEGAL_TRAP_INSN = 4'b1001,
    KIND_NOP = 4'b1010,
    KIND_SWRESET = 4'b1011,
    KIND_INSN_A = 4'b1100
  } dctu_kind_t;

  typedef enum logic [1:0] {
    FORM_CC_NOPRED = 2'b00,
    FORM_CC_PRED = 2'b01,
    FORM_REG = 2'b10,
    FORM_CALL = 2'b11
  } dctu_form_t;

endpackage : dctu_pkg

/* File: hdl/dctu_trap_stack.sv */
`timescale 1ns/1ps
module dctu_trap_stack #(
  parameter int DEPTH = 8,
  parameter int AW = 3,
  parameter int PC_W = 64,
  parameter int ST_W = 40
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_level,
  input wire logic [PC_W-1:0] wr_pc,
  input wire logic [PC_W-1:0] wr_next_pc,
  input wire logic [ST_W-1:0] wr_state,
  input wire logic [AW-1:0] rd_level,
  output logic [PC_W-1:0] rd_pc,
  output logic [PC_W-1:0] rd_next_pc,
  output logic [ST_W-1:0] rd_state
);

  logic [PC_W-1:0] pc_mem [DEPTH];
  logic [PC_W-1:0] npc_mem [DEPTH];
  logic [ST_W-1:0] st_mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      pc_mem[wr_level] <= wr_pc;
      npc_mem[wr_level] <= wr_next_pc;
      st_mem[wr_level] <= wr_state;
    end
  end

  // Read data is registered; a write shows up one edge later.
  always_ff @(posedge clk) begin
    rd_pc <= pc_mem[rd_level];
    rd_next_pc <= npc_mem[rd_level];
    rd_state <= st_mem[rd_level];
  end

endmodule : dctu_trap_stack

/* File: hdl/dctu_target.sv */
`timescale 1ns/1ps
module dctu_target
  import dctu_pkg::*;
(
  input wire logic [dctu_pkg::ADDR_W-1:0] pc,
  input wire logic [dctu_pkg::DISP_W-1:0] disp_word,
  input dctu_pkg::dctu_form_t disp_form,
  input wire logic [dctu_pkg::ADDR_W-1:0] first_source_reg,
  input wire logic [dctu_pkg::ADDR_W-1:0] second_source_reg,
  input wire logic imm_sel,
  input wire logic [dctu_pkg::IMM_W-1:0] signed_imm_field,
  input wire logic [dctu_pkg::TB_W-1:0] trap_base_reg,
  input wire logic tl_nonzero,
  output logic [dctu_pkg::ADDR_W-1:0] pcrel_target,
  output logic [dctu_pkg::ADDR_W-1:0] regind_target,
  output logic [dctu_pkg::TT_W-1:0] sw_trap_type,
  output logic [dctu_pkg::ADDR_W-1:0] trap_vector
);

  logic [ADDR_W-1:0] disp_sext;
  logic [ADDR_W-1:0] byte_disp;
  logic [ADDR_W-1:0] imm_sext;
  logic [ADDR_W-1:0] operand2;
  logic [ADDR_W-1:0] trap_sum;

  assign disp_sext = (disp_form == FORM_CC_NOPRED) ?
      {{(ADDR_W-DISP_CC_NOPRED_W){disp_word[DISP_CC_NOPRED_W-1]}},
       disp_word[DISP_CC_NOPRED_W-1:0]} :
    (disp_form == FORM_CC_PRED) ?
      {{(ADDR_W-DISP_CC_PRED_W){disp_word[DISP_CC_PRED_W-1]}},
       disp_word[DISP_CC_PRED_W-1:0]} :
    (disp_form == FORM_REG) ?
      {{(ADDR_W-DISP_REG_W){disp_word[DISP_REG_W-1]}}, disp_word[DISP_REG_W-1:0]} :
      {{(ADDR_W-DISP_CALL_W){disp_word[DISP_CALL_W-1]}}, disp_word[DISP_CALL_W-1:0]};

  assign byte_disp = {disp_sext[ADDR_W-WORD_SHIFT-1:0], {WORD_SHIFT{1'b0}}};
  assign pcrel_target = pc + byte_disp;

  assign imm_sext = {{(ADDR_W-IMM_W){signed_imm_field[IMM_W-1]}}, signed_imm_field};
  assign operand2 = imm_sel ? imm_sext : second_source_reg;
  assign regind_target = first_source_reg + operand2;

  assign trap_sum = first_source_reg + operand2;
  assign sw_trap_type = SW_TRAP_BASE + {{(TT_W-SW_TRAP_BITS){1'b0}}, trap_sum[SW_TRAP_BITS-1:0]};

  assign trap_vector = {trap_base_reg, tl_nonzero, sw_trap_type, {TT_LSB{1'b0}}};

endmodule : dctu_target

/* File: sim/dctu_unit_sva.sv */
`timescale 1ns/1ps
module dctu_unit_sva
  import dctu_pkg::*;
#(
  parameter int CWP_W = 3
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic insn_valid,
  input dctu_pkg::dctu_kind_t insn_kind,
  input wire logic cond_true,
  input wire logic annul,
  input wire logic [dctu_pkg::ADDR_W-1:0] first_source_reg,
  input wire logic [dctu_pkg::ADDR_W-1:0] second_source_reg,
  input wire logic imm_sel,
  input wire logic [dctu_pkg::IMM_W-1:0] signed_imm_field,
  input wire logic addr_mask_32_flag,
  input wire logic privileged,
  input wire logic [dctu_pkg::TB_W-1:0] trap_base_reg,
  input wire logic insn_ready,
  input wire logic [dctu_pkg::ADDR_W-1:0] prog_counter,
  input wire logic [dctu_pkg::ADDR_W-1:0] next_prog_counter,
  input wire logic [dctu_pkg::TL_W-1:0] trap_level,
  input wire logic [dctu_pkg::TT_W-1:0] trap_type_reg,
  input wire logic [CWP_W-1:0] current_window_pointer,
  input wire logic link_wr_en,
  input wire logic [dctu_pkg::REG_IDX_W-1:0] link_wr_idx,
  input wire logic [dctu_pkg::ADDR_W-1:0] link_wr_data,
  input wire logic state_restore,
  input wire logic trap_taken,
  input wire logic illegal_insn_exc
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  wire acc = insn_valid & insn_ready;
  wire [ADDR_W-1:0] opnd = imm_sel ? {{51{signed_imm_field[12]}}, signed_imm_field}
                                   : second_source_reg;
  wire [6:0] sum7 = 7'(first_source_reg + opnd);
  // A saturated trap level still takes the software trap but holds at TL_MAX, so that case is left out here.
  wire tcc_go = acc && insn_kind == KIND_TCOND && cond_true && trap_level < TL_MAX;
  //////////////////////////////
  noncti_step_a:
    assert property (acc && insn_kind == KIND_NONCTI |=> prog_counter == $past(next_prog_counter)
      && next_prog_counter == $past(next_prog_counter) + PC_STEP) else $error("plain step wrong");
  branch_taken_a:
    assert property (acc && insn_kind == KIND_BCOND && cond_true
      |=> prog_counter == $past(next_prog_counter)) else $error("taken branch PC wrong");
  annul_skip_a:
    assert property (acc && insn_kind == KIND_BCOND && annul && !cond_true
      |=> prog_counter == $past(next_prog_counter) + PC_STEP
      && next_prog_counter == $past(next_prog_counter) + PC_STEP2) else $error("annul skip wrong");
  call_link_a:
    assert property (acc && insn_kind == KIND_CALL |=> link_wr_en && link_wr_idx == LINK_REG
      && link_wr_data[31:0] == $past(prog_counter[31:0])) else $error("call link wrong");
  jlink_mask_a:
    assert property (acc && insn_kind == KIND_JLINK && addr_mask_32_flag
      |=> link_wr_en && link_wr_data[63:32] == UPPER_ZERO) else $error("link mask wrong");
  done_step_a:
    assert property (acc && insn_kind == KIND_DONE && privileged
      |=> state_restore && next_prog_counter == prog_counter + PC_STEP) else $error("done wrong");
  trap_entry_a:
    assert property (tcc_go |=> trap_level == $past(trap_level) + 3'h1 && !insn_ready
      ##1 insn_ready) else $error("trap entry wrong");
  trap_type_a:
    assert property (tcc_go |=> trap_taken && trap_type_reg == SW_TRAP_BASE + $past(sum7))
      else $error("trap type wrong");
  trap_vector_a:
    assert property (trap_taken |-> prog_counter[63:15] == $past(trap_base_reg)
      && prog_counter[13:0] == {trap_type_reg, 5'h0}
      && next_prog_counter == prog_counter + PC_STEP) else $error("trap vector wrong");
  illegal_exc_a:
    assert property (acc && insn_kind == KIND_ILLEGAL_TRAP_INSN |=> illegal_insn_exc
      && $stable(prog_counter)) else $error("illegal trap wrong");
  window_restore_a:
    assert property (acc && insn_kind == KIND_RETURN |=> current_window_pointer
      == $past(current_window_pointer) - 1'b1) else $error("window pointer wrong");
endmodule : dctu_unit_sva

/* File: sim/dctu_unit_tb.sv */
`timescale 1ns/1ps
module dctu_unit_tb;
  import dctu_pkg::*;
  logic clk, reset, insn_valid, cond_true, annul, imm_sel, addr_mask_32_flag, privileged;
  dctu_kind_t insn_kind, k;
  dctu_form_t disp_form, f;
  logic [DISP_W-1:0] disp_word, d;
  logic [ADDR_W-1:0] first_source_reg, second_source_reg, prog_counter, next_prog_counter;
  logic [ADDR_W-1:0] link_wr_data, p, q, t, sp, sq, s1;
  logic [IMM_W-1:0] signed_imm_field;
  logic [REG_IDX_W-1:0] dest_reg_idx, link_wr_idx;
  logic [TB_W-1:0] trap_base_reg;
  logic [39:0] machine_state, saved_trap_state;
  logic insn_ready, link_wr_en, state_restore, trap_taken, illegal_insn_exc;
  logic priv_opcode_exc, soft_reset_req, c, a;
  logic [TL_W-1:0] trap_level;
  logic [TT_W-1:0] trap_type_reg;
  logic [2:0] current_window_pointer;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  dctu_kind_t ks[4] = '{KIND_NONCTI, KIND_NOP, KIND_SWRESET, KIND_INSN_A};

  dctu_unit dctu_unit_i (
    .clk, .reset, .insn_valid, .insn_kind, .cond_true, .annul, .disp_word, .disp_form,
    .first_source_reg, .second_source_reg, .imm_sel, .signed_imm_field, .dest_reg_idx,
    .addr_mask_32_flag, .privileged, .trap_base_reg, .machine_state, .insn_ready,
    .prog_counter, .next_prog_counter, .trap_level, .trap_type_reg, .current_window_pointer,
    .link_wr_en, .link_wr_idx, .link_wr_data, .state_restore, .saved_trap_state, .trap_taken,
    .illegal_insn_exc, .priv_opcode_exc, .soft_reset_req
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  //////////////////////////////
  function automatic logic [63:0] boff(input logic [29:0] w, input dctu_form_t fm);
    case (fm)
      FORM_CC_NOPRED: return {{42{w[21]}}, w[21:0]} << 2;
      FORM_CC_PRED: return {{45{w[18]}}, w[18:0]} << 2;
      FORM_REG: return {{48{w[15]}}, w[15:0]} << 2;
      default: return {{34{w[29]}}, w} << 2;
    endcase
  endfunction : boff

  task automatic cmp(input logic [71:0] got, input logic [71:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  task automatic cpc();
    cmp(prog_counter, p);
    cmp(next_prog_counter, q);
  endtask : cpc

  // Holds the request until an edge sees ready, so a refused cycle is simply waited out.
  task automatic go(input dctu_kind_t kd, input logic cv, input logic av);
    int n;
    n = 0;
    @(posedge clk);
    insn_kind <= kd;
    cond_true <= cv;
    annul <= av;
    insn_valid <= 1'b1;
    @(posedge clk);
    while (insn_ready !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
    end
    if (insn_ready !== 1'b1) begin
      num_errors++;
      $display("[ERR] %0t request never taken", $time);
    end
    insn_valid <= 1'b0;
    @(negedge clk);
  endtask : go

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      num_errors++;
      $display("[ERR] %0t timeout", $time);
      give_verdict();
    end
  end

  //////////////////////////////
  initial begin
    reset = 1'b1;
    insn_valid = 1'b0;
    insn_kind = KIND_NOP;
    {cond_true, annul, imm_sel, addr_mask_32_flag, privileged} = 5'h0;
    disp_word = '0;
    disp_form = FORM_CC_NOPRED;
    first_source_reg = '0;
    second_source_reg = '0;
    signed_imm_field = '0;
    dest_reg_idx = 5'h09;
    trap_base_reg = 49'h0_1234_5678_9abc;
    machine_state = 40'h12_3456_789a;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    p = RESET_PC_VAL;
    q = PC_STEP;
    cpc();
    foreach (ks[i]) begin
      privileged <= (ks[i] == KIND_INSN_A);
      go(ks[i], 1'b0, 1'b0);
      p = q;
      q = q + 4;
      cpc();
      cmp({illegal_insn_exc, priv_opcode_exc, soft_reset_req, trap_taken}, 4'h0);
    end
    for (int i = 0; i < 8; i++) begin
      k = i[2] ? KIND_BUNCOND : KIND_BCOND;
      c = i[1];
      a = i[0];
      d = 30'h1ab4_9e65 + 30'(i << 17);
      f = dctu_form_t'(2'(i));
      disp_word <= d;
      disp_form <= f;
      t = p + boff(d, f);
      go(k, c, a);
      if (k == KIND_BUNCOND && c && a) begin
        p = t;
        q = t + 4;
      end else if (a && !c) begin
        p = q + 4;
        q = q + 8;
      end else begin
        p = q;
        q = c ? t : q + 4;
      end
      cpc();
    end
    first_source_reg <= 64'hfedc_ba98_7654_3000;
    second_source_reg <= 64'h0000_0000_0000_0ff0;
    addr_mask_32_flag <= 1'b1;
    t = p;
    go(KIND_JLINK, 1'b0, 1'b0);
    p = q;
    q = 64'hfedc_ba98_7654_3ff0;
    cpc();
    cmp({link_wr_en, link_wr_idx, link_wr_data}, {1'b1, 5'h09, 32'h0, t[31:0]});
    imm_sel <= 1'b1;
    signed_imm_field <= 13'h1ff0;
    addr_mask_32_flag <= 1'b0;
    t = p;
    go(KIND_JLINK, 1'b0, 1'b0);
    p = q;
    q = 64'hfedc_ba98_7654_2ff0;
    cpc();
    cmp(link_wr_data, t);
    go(KIND_NONCTI, 1'b0, 1'b0);
    addr_mask_32_flag <= 1'b1;
    disp_word <= 30'h3fff_fffc;
    disp_form <= FORM_CALL;
    t = q;
    p = q;
    q = q + 4;
    go(KIND_CALL, 1'b0, 1'b0);
    p = q;
    q = t - 64'h10;
    cpc();
    cmp({link_wr_en, link_wr_idx, link_wr_data}, {1'b1, LINK_REG, 32'h0, t[31:0]});
    first_source_reg <= 64'h0000_0000_0001_0000;
    signed_imm_field <= 13'h0020;
    go(KIND_RETURN, 1'b0, 1'b0);
    p = q;
    q = 64'h0000_0000_0001_0020;
    cpc();
    cmp(current_window_pointer, 3'h7);
    go(KIND_TCOND, 1'b0, 1'b0);
    p = q;
    q = q + 4;
    cpc();
    cmp({trap_taken, trap_level}, 4'h0);
    first_source_reg <= 64'h5;
    second_source_reg <= 64'h7f;
    imm_sel <= 1'b0;
    s1 = q;
    go(KIND_TCOND, 1'b1, 1'b0);
    // The level bit is clear here, since the trap level was zero before this trap.
    t = {trap_base_reg, 1'b0, 9'h104, 5'h0};
    cmp(prog_counter, t);
    cmp(next_prog_counter, t + 4);
    cmp({trap_taken, trap_level, trap_type_reg}, {1'b1, 3'h1, 9'h104});
    first_source_reg <= 64'h0000_0000_0002_0000;
    imm_sel <= 1'b1;
    signed_imm_field <= 13'h0000;
    go(KIND_JLINK, 1'b0, 1'b0);
    go(KIND_NONCTI, 1'b0, 1'b0);
    p = 64'h0000_0000_0002_0000;
    q = p + 4;
    cpc();
    sp = p;
    sq = q;
    first_source_reg <= 64'h3;
    signed_imm_field <= 13'h007b;
    machine_state <= 40'h0a_bcde_f012;
    go(KIND_TCOND, 1'b1, 1'b0);
    p = {trap_base_reg, 1'b1, 9'h17e, 5'h0};
    q = p + 4;
    cpc();
    cmp({trap_level, trap_type_reg}, {3'h2, 9'h17e});
    go(KIND_RETRY, 1'b0, 1'b0);
    p = sp;
    q = sq;
    cpc();
    cmp({state_restore, trap_level, saved_trap_state}, {1'b1, 3'h1, 40'h0a_bcde_f012});
    go(KIND_DONE, 1'b0, 1'b0);
    p = s1;
    q = s1 + 4;
    cpc();
    cmp({state_restore, trap_level, saved_trap_state}, {1'b1, 3'h0, 40'h12_3456_789a});
    go(KIND_ILLEGAL_TRAP_INSN, 1'b0, 1'b0);
    cpc();
    cmp(illegal_insn_exc, 1'b1);
    go(KIND_SWRESET, 1'b0, 1'b0);
    cpc();
    cmp({soft_reset_req, priv_opcode_exc}, 2'h2);
    privileged <= 1'b0;
    go(KIND_INSN_A, 1'b0, 1'b0);
    cpc();
    cmp({soft_reset_req, priv_opcode_exc}, 2'h1);
    go(KIND_DONE, 1'b0, 1'b0);
    cpc();
    cmp({priv_opcode_exc, state_restore, trap_level}, 5'h10);
    give_verdict();
  end
endmodule : dctu_unit_tb

bind dctu_unit dctu_unit_sva #(.CWP_W(CWP_W)) dctu_unit_sva_i (
  .clk, .reset, .insn_valid, .insn_kind, .cond_true, .annul, .first_source_reg,
  .second_source_reg, .imm_sel, .signed_imm_field, .addr_mask_32_flag, .privileged,
  .trap_base_reg, .insn_ready, .prog_counter, .next_prog_counter, .trap_level, .trap_type_reg,
  .current_window_pointer, .link_wr_en, .link_wr_idx, .link_wr_data, .state_restore,
  .trap_taken, .illegal_insn_exc
);
